// File: logic/ipr_pkg.sv
// constants for the interrupt priority field bank
// shared by the bank top and its field cell
package ipr_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int LVL_W = 3;
    localparam int NUM_SRC = 6;
    localparam logic [ADDR_W-1:0] OFF_CTRL_SIX = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_CTRL_SEVEN = 4'h1;
    localparam logic [LVL_W-1:0] LVL_RESET = 3'h4;
    localparam logic [LVL_W-1:0] LVL_OFF = 3'h0;
    localparam logic [LVL_W-1:0] LVL_MAX = 3'h7;
    localparam logic [LVL_W-1:0] LVL_MIN = 3'h1;
    // source indices
    localparam int SRC_TIMER_FOUR = 0;
    localparam int SRC_COMPARE_THREE = 1;
    localparam int SRC_UART_B_TX = 2;
    localparam int SRC_UART_B_RX = 3;
    localparam int SRC_EXT_IRQ_B = 4;
    localparam int SRC_TIMER_FIVE = 5;
    localparam logic [2:0] SRC_NONE = 3'h7;
    // register holding each source field, and the field's low bit
    localparam logic [ADDR_W-1:0] SRC_REG [NUM_SRC] = '{
        OFF_CTRL_SIX, OFF_CTRL_SIX, OFF_CTRL_SEVEN,
        OFF_CTRL_SEVEN, OFF_CTRL_SEVEN, OFF_CTRL_SEVEN};
    localparam int SRC_LSB [NUM_SRC] = '{12, 4, 12, 8, 4, 0};
    localparam logic [DATA_W-1:0] MASK_FIELDS = 16'h7777;
endpackage

// File: logic/ipr_field.sv
// one 3-bit priority field cell
// written by the bank's decode; same clock and reset as the bank
`timescale 1ns/100ps
module ipr_field
    import ipr_pkg::*;
(
    input wire logic i_sys_clk,            // system clock
    input wire logic i_rst,                // synchronous reset, high
    input wire logic i_we,                 // write this field
    input wire logic [LVL_W-1:0] i_wdata,  // new level code
    output logic [LVL_W-1:0] o_level       // stored level code
);
    logic [LVL_W-1:0] level_r;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
            level_r <= LVL_RESET;
        else if (i_we)
            level_r <= i_wdata;
    end

    assign o_level = level_r;
endmodule

// File: logic/ipr_bank.sv
// interrupt priority field bank with a pending-source selector
// registers reached over a plain strobe port; request flags come
// from logic on the same clock
//
// Overview of operation
// - code 111 means level seven, highest
// - 001 is level one; codes equal levels
// - code 000 disables source, never taken
// - unimplemented bits read zero, ignore writes
// - uart b transmit field at bits 14:12
// - uart b receive field at bits 10:8
// - timer four has read/write 3-bit field
// - external irq b field at bits 6:4
`timescale 1ns/100ps
module ipr_bank
    import ipr_pkg::*;
(
    input wire logic i_sys_clk,               // system clock, 40 MHz
    input wire logic i_rst,                   // synchronous reset, high
    input wire logic [ADDR_W-1:0] i_addr,     // register index
    input wire logic [DATA_W-1:0] i_wr_data,  // write data
    input wire logic i_wr,                    // write strobe
    input wire logic i_rd,                    // read strobe
    output logic [DATA_W-1:0] o_rd_data,      // read data, cycle after i_rd
    input wire logic [NUM_SRC-1:0] i_src_req, // pending flags per source
    output logic o_take,                      // a pending source is taken
    output logic [LVL_W-1:0] o_take_level,    // level of the taken source
    output logic [2:0] o_take_src,            // index of the taken source
    output logic [NUM_SRC-1:0] o_src_enabled  // field nonzero per source
);
    logic [LVL_W-1:0] level [NUM_SRC];
    logic [NUM_SRC-1:0] field_we;
    logic [DATA_W-1:0] rd_six;
    logic [DATA_W-1:0] rd_seven;
    logic [DATA_W-1:0] rd_sel;
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;
    logic [LVL_W-1:0] best_level;
    logic [2:0] best_src;
    logic take_r;
    logic [LVL_W-1:0] take_level_r;
    logic [2:0] take_src_r;
    logic [NUM_SRC-1:0] enabled_r;
    logic [NUM_SRC-1:0] enabled_nxt;

    // one field cell per source; decode picks the owning register
    for (genvar i = 0; i < NUM_SRC; i++)
    begin : g_src
        assign field_we[i] = i_wr && (i_addr == SRC_REG[i]);
        ipr_field u_field (
            .i_sys_clk (i_sys_clk),
            .i_rst     (i_rst),
            .i_we      (field_we[i]),
            .i_wdata   (i_wr_data[SRC_LSB[i] +: LVL_W]),
            .o_level   (level[i])
        );
        assign enabled_nxt[i] = (level[i] != LVL_OFF);
    end

    assign rd_six = {1'h0, level[SRC_TIMER_FOUR], 5'h00,
                     level[SRC_COMPARE_THREE], 4'h0};
    assign rd_seven = {1'h0, level[SRC_UART_B_TX], 1'h0,
                       level[SRC_UART_B_RX], 1'h0,
                       level[SRC_EXT_IRQ_B], 1'h0,
                       level[SRC_TIMER_FIVE]};
    // unused bits and addresses read zero
    assign rd_sel = (i_addr == OFF_CTRL_SIX) ? (rd_six & MASK_FIELDS) :
                    (i_addr == OFF_CTRL_SEVEN) ? (rd_seven & MASK_FIELDS) :
                    16'h0000;
    assign rd_data_nxt = i_rd ? rd_sel : 16'h0000;

    // highest level wins; ties go to the lower source index
    always_comb
    begin
        best_level = LVL_OFF;
        best_src = SRC_NONE;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (i_src_req[i] && (level[i] != LVL_OFF) && (level[i] > best_level))
            begin
                best_level = level[i];
                best_src = 3'(i);
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            rd_data_r <= 16'h0000;
            take_r <= 1'h0;
            take_level_r <= LVL_OFF;
            take_src_r <= SRC_NONE;
            enabled_r <= '0;
        end
        else
        begin
            rd_data_r <= rd_data_nxt;
            take_r <= (best_level != LVL_OFF);
            take_level_r <= best_level;
            take_src_r <= best_src;
            enabled_r <= enabled_nxt;
        end
    end

    assign o_rd_data = rd_data_r;
    assign o_take = take_r;
    assign o_take_level = take_level_r;
    assign o_take_src = take_src_r;
    assign o_src_enabled = enabled_r;
endmodule

// File: verification/ipr_bank_chk.sv
// port checker for the priority bank
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module ipr_bank_chk
    import ipr_pkg::*;
(
    input wire logic i_sys_clk, // clock
    input wire logic i_rst, // reset
    input wire logic [ADDR_W-1:0] i_addr, // index
    input wire logic [DATA_W-1:0] i_wr_data, // wdata
    input wire logic i_wr, // write
    input wire logic i_rd, // read
    input wire logic [DATA_W-1:0] o_rd_data, // rdata
    input wire logic [NUM_SRC-1:0] i_src_req, // flags
    input wire logic o_take, // taken
    input wire logic [LVL_W-1:0] o_take_level, // level
    input wire logic [2:0] o_take_src, // source
    input wire logic [NUM_SRC-1:0] o_src_enabled // enables
);
logic rst_d_r;
always_ff @(posedge i_sys_clk) rst_d_r <= i_rst;
default clocking @(posedge i_sys_clk); endclocking
default disable iff (i_rst);
sequence s_wr_rd;
    i_wr && i_addr == OFF_CTRL_SEVEN ##1 i_rd && i_addr == OFF_CTRL_SEVEN;
endsequence
a_rd_idle_zero: assert property (!i_rd |=> o_rd_data == '0) else $error("rd idle");
a_unimpl_bits: assert property ((o_rd_data & ~MASK_FIELDS) == '0) else $error("unimpl");
a_write_read: assert property (
    s_wr_rd |=> o_rd_data == ($past(i_wr_data, 2) & MASK_FIELDS)) else $error("readback");
a_take_level_set: assert property (o_take |-> o_take_level != LVL_OFF) else $error("lvl0");
a_no_req_take: assert property (i_src_req == '0 |=> !o_take) else $error("no req");
a_take_req_src: assert property (
    o_take |-> ($past(i_src_req) >> o_take_src) & 6'h01) else $error("src");
a_idle_outputs: assert property (
    !o_take |-> o_take_src == SRC_NONE && o_take_level == LVL_OFF) else $error("idle");
a_reset_all_on: assert property (
    rst_d_r && !i_rst |=> o_src_enabled == 6'h3F) else $error("reset");
endmodule
bind ipr_bank ipr_bank_chk u_ipr_bank_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_src_req(i_src_req), .o_take(o_take), .o_take_level(o_take_level),
    .o_take_src(o_take_src), .o_src_enabled(o_src_enabled));

// File: verification/interrupt_priority_config_test.sv
// testbench for the priority bank
// drives the register port and request flags itself
`timescale 1ns/100ps
module interrupt_priority_config_test import ipr_pkg::*;;
logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, tk;
logic [3:0] a = 4'h0;
logic [15:0] wd = 16'h0000, rdd;
logic [5:0] req = 6'h00;
logic [5:0] en;
logic [2:0] lv, sr;
int failures = 0, n_compared = 0;
logic [35:0] rows [5] = '{{4'h1, 16'hFFFF, 16'h7777}, {4'h1, 16'h1234, 16'h1234},
    {4'h0, 16'hFFFF, 16'h7070}, {4'h0, 16'h2050, 16'h2050}, {4'h2, 16'hFFFF, 16'h0000}};
ipr_bank u_ipr_bank (.i_sys_clk(clk), .i_rst(rst), .i_addr(a), .i_wr_data(wd), .i_wr(wr),
    .i_rd(rd), .o_rd_data(rdd), .i_src_req(req), .o_take(tk), .o_take_level(lv),
    .o_take_src(sr), .o_src_enabled(en));
initial
    forever #12.5 clk = ~clk;
task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
        failures++;
        $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
endtask
task test_done;
    if (failures == 0 && n_compared > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
// optional write, then read back
task acc(input logic [3:0] ad, input logic [15:0] d, input logic w, input logic [15:0] e);
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= w;
    @(posedge clk);
    wr <= 0;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdd, e);
endtask
task sel(input logic [5:0] r, input logic [15:0] e);
    @(posedge clk);
    req <= r;
    @(posedge clk);
    #1 chk({9'h000, tk, lv, sr}, e);
endtask
initial
begin
    repeat (12) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 5; i++)
        acc(rows[i][35:32], rows[i][31:16], 1'h1, rows[i][15:0]);
    @(posedge clk);
    rst <= 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    acc(4'h0, 16'h0000, 1'h0, 16'h4040);
    chk({10'h000, en}, 16'h003F);
    acc(4'h1, 16'h0000, 1'h0, 16'h4444);
    sel(6'h3F, 16'h0060);
    acc(4'h1, 16'h7010, 1'h1, 16'h7010);
    acc(4'h0, 16'h0000, 1'h1, 16'h0000);
    chk({10'h000, en}, 16'h0014);
    sel(6'h3F, 16'h007A);
    sel(6'h18, 16'h004C);
    sel(6'h09, 16'h0007);
    test_done();
end
endmodule
